// ==== rtl/gpioaf_params.svh ====
// register offsets, field positions and reset values of the gpio port block
`ifndef GPIOAF_PARAMS_SVH
`define GPIOAF_PARAMS_SVH
`define GPIOAF_PINS 8
`define GPIOAF_ADDR_W 8
`define GPIOAF_OFS_A_DATA 8'h00
`define GPIOAF_OFS_A_DIR 8'h04
`define GPIOAF_OFS_B_DATA 8'h08
`define GPIOAF_OFS_B_DIR 8'h0c
`define GPIOAF_OFS_A_IRQ_EN 8'h10
`define GPIOAF_OFS_B_IRQ_EN 8'h14
`define GPIOAF_OFS_A_IRQ_POL 8'h18
`define GPIOAF_OFS_B_IRQ_POL 8'h1c
`define GPIOAF_OFS_MISC 8'h20
`define GPIOAF_MISC_CLK_BIT 0
`define GPIOAF_MISC_USB_BIT 1
`define GPIOAF_MISC_SLOW_LSB 2
`define GPIOAF_MISC_SLOW_MSB 3
`define GPIOAF_MISC_USED_MASK 8'h0f
`define GPIOAF_RST_PORT 8'h00
`define GPIOAF_RST_MISC 8'h00
`define GPIOAF_RESP_OKAY 2'b00
`define GPIOAF_RESP_SLVERR 2'b10
`endif

// ==== rtl/gpioaf_pkg.sv ====
// types shared by the gpio port block
package gpioaf_pkg;
`include "gpioaf_params.svh"

    typedef struct packed {
        logic awvalid;
        logic [`GPIOAF_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`GPIOAF_ADDR_W-1:0] araddr;
        logic rready;
    } gpioaf_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gpioaf_axil_rsp_t;

    typedef struct packed {
        logic [`GPIOAF_PINS-1:0] out;
        logic [`GPIOAF_PINS-1:0] oe;
    } gpioaf_pin_drive_t;

    typedef struct packed {
        logic [`GPIOAF_PINS-1:0] en;
        logic [`GPIOAF_PINS-1:0] out;
        logic [`GPIOAF_PINS-1:0] od;
    } gpioaf_alt_t;

    typedef struct packed {
        logic aw_held;
        logic [`GPIOAF_ADDR_W-1:0] awaddr;
        logic w_held;
        logic [7:0] wdata;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] data_a;
        logic [7:0] dir_a;
        logic [7:0] data_b;
        logic [7:0] dir_b;
        logic [7:0] irq_en_a;
        logic [7:0] irq_en_b;
        logic [7:0] irq_pol_a;
        logic [7:0] irq_pol_b;
        logic [7:0] misc;
        logic clk_phase;
        logic [7:0] alt_en_a;
        logic [7:0] alt_en_b;
        gpioaf_pin_drive_t drv_a;
        gpioaf_pin_drive_t drv_b;
    } gpioaf_state_t;
endpackage

// ==== rtl/gpioaf_sync.sv ====
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
module gpioaf_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } gpioaf_sync_st_t;

    gpioaf_sync_st_t st;
    gpioaf_sync_st_t next_st;

    always_comb begin
        next_st.meta = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule

// ==== rtl/gpioaf_irq.sv ====
// edge detection and request latch for one interrupt vector
`timescale 1ns/10ps
module gpioaf_irq
    import gpioaf_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] polarity,
    input wire logic [WIDTH-1:0] enable,
    input wire logic [WIDTH-1:0] direction,
    input wire logic ack,
    output logic req
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic req;
    } gpioaf_irq_st_t;

    gpioaf_irq_st_t st;
    gpioaf_irq_st_t next_st;
    logic [WIDTH-1:0] edge_seen;
    logic [WIDTH-1:0] hit;

    always_comb begin
        // polarity 1 rising, 0 falling
        edge_seen = (polarity & level & ~st.prev) | (~polarity & ~level & st.prev);
        hit = edge_seen & enable & ~direction;
        next_st.prev = level;
        next_st.req = (st.req & ~ack) | (|hit);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign req = st.req;

    default clocking gpioaf_irq_cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_IRQ_SET_WINS: assert property (ce && (|hit) |=> req)
        else $error("pin event lost");
    AST_IRQ_CAUSE: assert property ($rose(req) |-> $past(|(edge_seen & enable & ~direction)))
        else $error("request without enabled input-mode event");
endmodule

// ==== rtl/gpioaf_top.sv ====
// gpio ports a and b with alternate functions, interrupts and misc register
`timescale 1ns/10ps
`include "gpioaf_params.svh"
module gpioaf_top
    import gpioaf_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire gpioaf_axil_req_t axi_req,
    output gpioaf_axil_rsp_t axi_rsp,
    input wire logic [7:0] pin_a_in,
    input wire logic [7:0] pin_b_in,
    output gpioaf_pin_drive_t pin_a,
    output gpioaf_pin_drive_t pin_b,
    input wire gpioaf_alt_t alt_a,
    input wire gpioaf_alt_t alt_b,
    output logic [7:0] periph_in_a,
    output logic [7:0] periph_in_b,
    input wire logic usb_tx_enable_out,
    output logic [1:0] slow_divider_select,
    output logic ext_irq_a,
    output logic ext_irq_b,
    input wire logic ext_irq_ack_a,
    input wire logic ext_irq_ack_b
);
    gpioaf_state_t st;
    gpioaf_state_t next_st;
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic ar_hs;
    logic r_hs;
    logic wr_fire;
    logic [`GPIOAF_ADDR_W-1:0] wr_word;
    logic [`GPIOAF_ADDR_W-1:0] rd_word;
    logic [7:0] wr_val;
    logic wr_lane;
    logic [7:0] read_a;
    logic [7:0] read_b;
    gpioaf_alt_t eff_a;
    gpioaf_alt_t eff_b;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [`GPIOAF_ADDR_W-1:0] word);
        logic hit;
        hit = 1'b1;
        unique case (word)
            `GPIOAF_OFS_A_DATA, `GPIOAF_OFS_A_DIR, `GPIOAF_OFS_B_DATA, `GPIOAF_OFS_B_DIR,
            `GPIOAF_OFS_A_IRQ_EN, `GPIOAF_OFS_B_IRQ_EN, `GPIOAF_OFS_A_IRQ_POL,
            `GPIOAF_OFS_B_IRQ_POL, `GPIOAF_OFS_MISC: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // latch for output pins, pin level for inputs
    function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                             input logic [7:0] level);
        return (dir & latch) | (~dir & level);
    endfunction

    function automatic gpioaf_pin_drive_t pin_drive(input logic [7:0] latch, input logic [7:0] dir,
                                                  input gpioaf_alt_t alt);
        gpioaf_pin_drive_t d;
        d.out = (alt.en & alt.out) | (~alt.en & latch);
        // open-drain peripheral output releases the pin for a one
        d.oe = (alt.en & ~(alt.od & alt.out)) | (~alt.en & dir);
        return d;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and interrupt vectors
    // ------------------------------------------------------------
    gpioaf_sync #(.WIDTH(8)) u_sync_a (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .async_in(pin_a_in),
        .sync_out(sync_a)
    );

    gpioaf_sync #(.WIDTH(8)) u_sync_b (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .async_in(pin_b_in),
        .sync_out(sync_b)
    );

    gpioaf_irq #(.WIDTH(8)) u_irq_a (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .level(sync_a),
        .polarity(st.irq_pol_a),
        .enable(st.irq_en_a),
        .direction(st.dir_a | st.alt_en_a),
        .ack(ext_irq_ack_a),
        .req(ext_irq_a)
    );

    gpioaf_irq #(.WIDTH(8)) u_irq_b (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .level(sync_b),
        .polarity(st.irq_pol_b),
        .enable(st.irq_en_b),
        .direction(st.dir_b | st.alt_en_b),
        .ack(ext_irq_ack_b),
        .req(ext_irq_b)
    );

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    always_comb begin
        axi_rsp.awready = ce & ~st.aw_held & ~st.bvalid;
        axi_rsp.wready = ce & ~st.w_held & ~st.bvalid;
        axi_rsp.bvalid = ce & st.bvalid;
        axi_rsp.bresp = st.bresp;
        axi_rsp.arready = ce & ~st.rvalid;
        axi_rsp.rvalid = ce & st.rvalid;
        axi_rsp.rdata = {24'h000000, st.rdata};
        axi_rsp.rresp = st.rresp;
    end

    assign aw_hs = axi_req.awvalid & axi_rsp.awready;
    assign w_hs = axi_req.wvalid & axi_rsp.wready;
    assign b_hs = axi_req.bready & axi_rsp.bvalid;
    assign ar_hs = axi_req.arvalid & axi_rsp.arready;
    assign r_hs = axi_req.rready & axi_rsp.rvalid;
    assign wr_word = {(st.aw_held ? st.awaddr[`GPIOAF_ADDR_W-1:2] : axi_req.awaddr[`GPIOAF_ADDR_W-1:2]), 2'b00};
    assign rd_word = {axi_req.araddr[`GPIOAF_ADDR_W-1:2], 2'b00};
    assign wr_val = st.w_held ? st.wdata : axi_req.wdata[7:0];
    assign wr_lane = st.w_held ? st.wlane : axi_req.wstrb[0];
    assign wr_fire = (st.aw_held | aw_hs) & (st.w_held | w_hs) & ~st.bvalid & ce;
    assign read_a = port_read(st.dir_a, st.data_a, sync_a);
    assign read_b = port_read(st.dir_b, st.data_b, sync_b);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (aw_hs) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = axi_req.awaddr;
        end
        if (w_hs) begin
            next_st.w_held = 1'b1;
            next_st.wdata = axi_req.wdata[7:0];
            next_st.wlane = axi_req.wstrb[0];
        end
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(wr_word) ? `GPIOAF_RESP_OKAY : `GPIOAF_RESP_SLVERR;
            if (wr_lane) begin
                unique case (wr_word)
                    `GPIOAF_OFS_A_DATA: next_st.data_a = wr_val;
                    `GPIOAF_OFS_A_DIR: next_st.dir_a = wr_val;
                    `GPIOAF_OFS_B_DATA: next_st.data_b = wr_val;
                    `GPIOAF_OFS_B_DIR: next_st.dir_b = wr_val;
                    `GPIOAF_OFS_A_IRQ_EN: next_st.irq_en_a = wr_val;
                    `GPIOAF_OFS_B_IRQ_EN: next_st.irq_en_b = wr_val;
                    `GPIOAF_OFS_A_IRQ_POL: next_st.irq_pol_a = wr_val;
                    `GPIOAF_OFS_B_IRQ_POL: next_st.irq_pol_b = wr_val;
                    `GPIOAF_OFS_MISC: next_st.misc = wr_val & `GPIOAF_MISC_USED_MASK;
                    default: next_st.misc = st.misc;
                endcase
            end
        end
        if (b_hs) begin
            next_st.bvalid = 1'b0;
        end
        if (ar_hs) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = mapped(rd_word) ? `GPIOAF_RESP_OKAY : `GPIOAF_RESP_SLVERR;
            unique case (rd_word)
                `GPIOAF_OFS_A_DATA: next_st.rdata = read_a;
                `GPIOAF_OFS_A_DIR: next_st.rdata = st.dir_a;
                `GPIOAF_OFS_B_DATA: next_st.rdata = read_b;
                `GPIOAF_OFS_B_DIR: next_st.rdata = st.dir_b;
                `GPIOAF_OFS_A_IRQ_EN: next_st.rdata = st.irq_en_a;
                `GPIOAF_OFS_B_IRQ_EN: next_st.rdata = st.irq_en_b;
                `GPIOAF_OFS_A_IRQ_POL: next_st.rdata = st.irq_pol_a;
                `GPIOAF_OFS_B_IRQ_POL: next_st.rdata = st.irq_pol_b;
                `GPIOAF_OFS_MISC: next_st.rdata = st.misc;
                default: next_st.rdata = 8'h00;
            endcase
        end else if (r_hs) begin
            next_st.rvalid = 1'b0;
        end

        // clock out runs at half the core rate from a flop
        next_st.clk_phase = next_st.misc[`GPIOAF_MISC_CLK_BIT] ? ~st.clk_phase : 1'b0;

        eff_a = alt_a;
        eff_b = alt_b;
        if (next_st.misc[`GPIOAF_MISC_USB_BIT]) begin
            eff_a.en[0] = 1'b1;
            eff_a.out[0] = usb_tx_enable_out;
            eff_a.od[0] = 1'b0;
        end
        if (next_st.misc[`GPIOAF_MISC_CLK_BIT]) begin
            eff_b.en[0] = 1'b1;
            eff_b.out[0] = next_st.clk_phase;
            eff_b.od[0] = 1'b0;
        end
        next_st.alt_en_a = eff_a.en;
        next_st.alt_en_b = eff_b.en;
        // pins follow the registers written at this same edge
        next_st.drv_a = pin_drive(next_st.data_a, next_st.dir_a, eff_a);
        next_st.drv_b = pin_drive(next_st.data_b, next_st.dir_b, eff_b);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
            st.data_a <= `GPIOAF_RST_PORT;
            st.dir_a <= `GPIOAF_RST_PORT;
            st.data_b <= `GPIOAF_RST_PORT;
            st.dir_b <= `GPIOAF_RST_PORT;
            st.misc <= `GPIOAF_RST_MISC;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pin_a = st.drv_a;
    assign pin_b = st.drv_b;
    assign periph_in_a = sync_a;
    assign periph_in_b = sync_b;
    assign slow_divider_select = st.misc[`GPIOAF_MISC_SLOW_MSB:`GPIOAF_MISC_SLOW_LSB];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking gpioaf_cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_RESET_INPUT_MODE: assert property ($past(rst) |-> st.dir_a == 8'h00 && st.data_a == 8'h00 &&
                                           st.dir_b == 8'h00 && pin_a.oe == 8'h00)
        else $error("port not cleared by reset");
    AST_READ_PORT_A: assert property (ar_hs && rd_word == `GPIOAF_OFS_A_DATA |=>
                                      st.rvalid && st.rdata == $past(read_a))
        else $error("port a read value wrong");
    AST_LATCH_WHILE_INPUT: assert property (wr_fire && wr_lane && wr_word == `GPIOAF_OFS_A_DATA &&
                                            st.dir_a == 8'h00 |=> st.data_a == $past(wr_val))
        else $error("latch not updated in input mode");
    AST_DIR_TO_PIN: assert property (wr_fire && wr_lane && wr_word == `GPIOAF_OFS_B_DIR |=>
                                     (pin_b.oe & ~st.alt_en_b) == ($past(wr_val) & ~st.alt_en_b))
        else $error("direction write not seen on pin");
    AST_ALT_PUSH_PULL: assert property (ce && (alt_a.en & ~alt_a.od) != 8'h00 |=>
                                        (pin_a.oe & $past(alt_a.en & ~alt_a.od)) == $past(alt_a.en & ~alt_a.od))
        else $error("peripheral output did not take the pin");
    AST_USB_ROUTE: assert property (ce && next_st.misc[`GPIOAF_MISC_USB_BIT] |=>
                                    pin_a.oe[0] && pin_a.out[0] == $past(usb_tx_enable_out))
        else $error("usb transmit enable not on pin a0");
    AST_CLOCK_OUT_TOGGLES: assert property (ce && st.misc[`GPIOAF_MISC_CLK_BIT] &&
                                            next_st.misc[`GPIOAF_MISC_CLK_BIT] |=> pin_b.out[0] != $past(pin_b.out[0]))
        else $error("clock out not toggling");
    AST_MISC_RESERVED: assert property (ar_hs && rd_word == `GPIOAF_OFS_MISC |=> st.rdata[7:4] == 4'h0)
        else $error("reserved misc bits read nonzero");
    AST_WRITE_RESPONSE: assert property (wr_fire |=> st.bvalid ##0 !axi_rsp.awready)
        else $error("write response missing");
endmodule

// ==== verif/gpioaf_pins_model.sv ====
// external pin world of one port: board drivers and pull-ups
`timescale 1ns/10ps
module gpioaf_pins_model
    import gpioaf_pkg::*;
(
    input wire gpioaf_pin_drive_t drv,
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] ext_oe,
    output logic [7:0] level
);
    // ------------------------------
    // wire level per pin
    // ------------------------------
    // released pins float up; open drain relies on this
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = drv.oe[i] ? drv.out[i] : (ext_oe[i] ? ext_lvl[i] : 1'b1);
        end
    end
endmodule

// ==== verif/gpioaf_bench.sv ====
// self-checking bench for the gpio port block
`timescale 1ns/10ps
`include "gpioaf_params.svh"
module gpioaf_bench
    import gpioaf_pkg::*;
;
    logic clock, rst, ce, usb, irq_a, irq_b, ack_a, ack_b;
    gpioaf_axil_req_t req;
    gpioaf_axil_rsp_t rsp;
    gpioaf_pin_drive_t pin_a, pin_b;
    gpioaf_alt_t alt_a, alt_b;
    logic [7:0] lvl_a, lvl_b, per_a, per_b, rd;
    logic [7:0] ext_lvl[2];
    logic [7:0] ext_oe[2];
    logic [1:0] slow, rr;
    int n_errors, samples_checked;

    gpioaf_top i_dut (.clock(clock), .rst(rst), .ce(ce), .axi_req(req), .axi_rsp(rsp), .pin_a_in(lvl_a),
        .pin_b_in(lvl_b), .pin_a(pin_a), .pin_b(pin_b), .alt_a(alt_a), .alt_b(alt_b), .periph_in_a(per_a),
        .periph_in_b(per_b), .usb_tx_enable_out(usb), .slow_divider_select(slow), .ext_irq_a(irq_a),
        .ext_irq_b(irq_b), .ext_irq_ack_a(ack_a), .ext_irq_ack_b(ack_b));
    gpioaf_pins_model i_pins_a (.drv(pin_a), .ext_lvl(ext_lvl[0]), .ext_oe(ext_oe[0]), .level(lvl_a));
    gpioaf_pins_model i_pins_b (.drv(pin_b), .ext_lvl(ext_lvl[1]), .ext_oe(ext_oe[1]), .level(lvl_b));

    // ------------------------------
    // helpers
    // ------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ready is judged before the edge it is sampled on
    task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, done;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        done = 1'b0;
        r = 2'b11;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clock);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            done = rsp.bvalid;
            if (done) r = rsp.bresp;
            @(posedge clock);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end
        if (!done) chk("write wait", 8'h01, 8'h00);
    endtask

    task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        logic ta, done;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        done = 1'b0;
        r = 2'b11;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clock);
            ta = req.arvalid & rsp.arready;
            done = rsp.rvalid;
            if (done) d = rsp.rdata[7:0];
            if (done) r = rsp.rresp;
            @(posedge clock);
            if (ta) req.arvalid <= 1'b0;
        end
        if (!done) chk("read wait", 8'h01, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk("bresp", {6'h0, `GPIOAF_RESP_OKAY}, {6'h0, r});
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(name, exp, d);
        chk("rresp", {6'h0, `GPIOAF_RESP_OKAY}, {6'h0, r});
    endtask

    task automatic irq_within(input logic [7:0] exp);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(negedge clock);
            seen = seen | irq_a;
        end
        chk("irq a", exp, {7'h0, seen});
        @(posedge clock);
    endtask

    task automatic ack;
        @(posedge clock);
        ack_a <= 1'b1;
        @(posedge clock);
        ack_a <= 1'b0;
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset;
        logic [7:0] ofs[7] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
        foreach (ofs[i]) rdc("reset reg", ofs[i], 8'h00);
        rdc("input read", `GPIOAF_OFS_A_DATA, 8'h3c);
        @(negedge clock);
        chk("reset oe", 8'h00, pin_a.oe | pin_b.oe);
        chk("reset slow", 8'h00, {6'h0, slow});
        @(posedge clock);
    endtask

    task automatic t_port(input int b);
        logic [7:0] base;
        gpioaf_pin_drive_t p;
        base = (b == 1) ? `GPIOAF_OFS_B_DATA : `GPIOAF_OFS_A_DATA;
        ext_lvl[b] <= 8'h5a;
        wr(base, 8'hc3);
        rdc("input data", base, 8'h5a);
        ext_oe[b] <= 8'hf0;
        wr(base + 8'h04, 8'h0f);
        rdc("mixed data", base, 8'h53);
        @(negedge clock);
        p = (b == 1) ? pin_b : pin_a;
        chk("mixed oe", 8'h0f, p.oe);
        @(posedge clock);
        wr(base + 8'h04, 8'hff);
        rdc("latch data", base, 8'hc3);
        @(negedge clock);
        p = (b == 1) ? pin_b : pin_a;
        chk("latch out", 8'hc3, p.out);
        @(posedge clock);
        wr(base + 8'h04, 8'h00);
        ext_oe[b] <= 8'hff;
    endtask

    task automatic t_misc;
        logic x;
        wr(`GPIOAF_OFS_MISC, 8'hff);
        rdc("misc", `GPIOAF_OFS_MISC, 8'h0f);
        usb <= 1'b1;
        repeat (2) @(negedge clock);
        chk("usb pin", 8'h03, {6'h0, pin_a.out[0], pin_a.oe[0]});
        chk("slow", 8'h03, {6'h0, slow});
        x = pin_b.out[0];
        @(negedge clock);
        chk("clock out", {7'h0, ~x}, {7'h0, pin_b.out[0]});
        chk("clock oe", 8'h01, {7'h0, pin_b.oe[0]});
        @(posedge clock);
        usb <= 1'b0;
        repeat (2) @(negedge clock);
        chk("usb idle", 8'h01, {6'h0, pin_a.out[0], pin_a.oe[0]});
        @(posedge clock);
        wr(`GPIOAF_OFS_MISC, 8'h00);
        @(negedge clock);
        chk("free pins", 8'h00, {6'h0, pin_a.oe[0], pin_b.oe[0]});
        @(posedge clock);
    endtask

    task automatic t_alt;
        alt_a.en <= 8'h80;
        alt_a.out <= 8'h80;
        repeat (2) @(negedge clock);
        chk("alt push", 8'h03, {6'h0, pin_a.out[7], pin_a.oe[7]});
        @(posedge clock);
        alt_a.od <= 8'h80;
        repeat (2) @(negedge clock);
        chk("alt drain", 8'h00, {7'h0, pin_a.oe[7]});
        @(posedge clock);
        alt_a <= '0;
        ext_lvl[1] <= 8'ha5;
        repeat (4) @(negedge clock);
        chk("periph in", 8'ha5, per_b);
        @(posedge clock);
        rdc("periph data", `GPIOAF_OFS_B_DATA, 8'ha5);
    endtask

    task automatic t_irq;
        ext_lvl[0] <= 8'hff;
        wr(`GPIOAF_OFS_A_IRQ_POL, 8'h00);
        wr(`GPIOAF_OFS_A_IRQ_EN, 8'h24);
        ack();
        irq_within(8'h00);
        ext_lvl[0] <= 8'hfb;
        irq_within(8'h01);
        ack();
        ext_lvl[0] <= 8'hff;
        irq_within(8'h00);
        ext_lvl[0] <= 8'hdf;
        irq_within(8'h01);
        ack();
        wr(`GPIOAF_OFS_A_DATA, 8'hff);
        ext_oe[0] <= 8'hdb;
        wr(`GPIOAF_OFS_A_DIR, 8'h24);
        wr(`GPIOAF_OFS_A_DATA, 8'h00);
        ack();
        irq_within(8'h00);
        wr(`GPIOAF_OFS_A_DIR, 8'h00);
        ext_oe[0] <= 8'hff;
    endtask

    // port b vector with rising sensitivity
    task automatic t_irq_b;
        logic seen;
        wr(`GPIOAF_OFS_B_IRQ_POL, 8'h01);
        wr(`GPIOAF_OFS_B_IRQ_EN, 8'h01);
        ext_lvl[1] <= 8'ha4;
        seen = 1'b0;
        repeat (8) @(negedge clock) seen = seen | irq_b;
        chk("irq b fall", 8'h00, {7'h0, seen});
        @(posedge clock);
        ext_lvl[1] <= 8'ha5;
        seen = 1'b0;
        repeat (8) @(negedge clock) seen = seen | irq_b;
        chk("irq b rise", 8'h01, {7'h0, seen});
        @(posedge clock);
        wr(`GPIOAF_OFS_B_IRQ_EN, 8'h00);
    endtask

    task automatic t_unmapped;
        axr(8'h24, rd, rr);
        chk("bad rdata", 8'h00, rd);
        chk("bad rresp", {6'h0, `GPIOAF_RESP_SLVERR}, {6'h0, rr});
        axw(8'h24, 8'hff, rr);
        chk("bad bresp", {6'h0, `GPIOAF_RESP_SLVERR}, {6'h0, rr});
        rdc("misc kept", `GPIOAF_OFS_MISC, 8'h00);
    endtask

    // ------------------------------
    // run control
    // ------------------------------
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        #300000;
        n_errors++;
        test_done();
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        ce = 1'b1;
        usb = 1'b0;
        ack_a = 1'b0;
        ack_b = 1'b0;
        alt_a = '0;
        alt_b = '0;
        ext_lvl = '{8'h3c, 8'h3c};
        ext_oe = '{8'hff, 8'hff};
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_port(0);
        t_port(1);
        t_misc();
        t_alt();
        t_irq();
        t_irq_b();
        t_unmapped();
        test_done();
    end
endmodule
